// ### inc/cml_pkg.sv
// Package for the cascaded motor loop control: modes, gains, limits and carriers
// Function
// - Current loop runs in every operating mode.
// - Velocity loop runs in closed loop (submode bit 0), except in unlimited torque mode, submode bit 5 set.
// - Position loop runs in closed loop (submode bit 0), in position-type modes, or velocity modes with submode bit 1.
// - Each loop output feeds next set point, clamped to speed, current, PWM limits.
// - At unity gain, maximum deviation gives exactly maximum output, linear below.
// - Proportional part scales directly with the loop's gain.
// - Shorter reset time integrates faster; zero reset time clears integral term.
// - Legacy parameters active until legacy select zero; then converted at switch-on.
// - Velocity feed-forward is ramp velocity times factor in tenths percent.
// - Velocity feed-forward only where the position loop runs.
// - Acceleration feed-forward is ramp acceleration times factor and scale constant.
// - Acceleration feed-forward applies except in torque modes.
// - Voltage feed-forward scaled in tenths percent of rated voltage, default full.
// - Voltage feed-forward always active; factor zero disables it.
// - Velocity and acceleration feed-forward add to loop set points; voltage feed-forward joins after the integral.
package cml_pkg;

  localparam int DW = 32;
  localparam int GW = 16;

  typedef enum logic [3:0] {
    CML_PROFILE_POS, CML_VELOCITY, CML_PROFILE_VEL, CML_PROFILE_TRQ, CML_HOMING,
    CML_INTERP_POS, CML_CYC_POS, CML_CYC_VEL, CML_CYC_TRQ, CML_CLOCK_DIR
  } cml_mode_t;

  localparam int SUB_LOOP_SELECT = 0;
  localparam int SUB_POS_IN_VEL  = 1;
  localparam int SUB_REAL_TORQUE = 5;

  localparam logic [GW-1:0] PERMILLE_FULL    = 16'h03E8;
  localparam logic [GW-1:0] GAIN_UNITY       = 16'h03E8;
  localparam int            PERMILLE_SHIFT   = 10;
  localparam logic [GW-1:0] VOLT_FF_DEFAULT  = 16'h03E8;
  localparam logic [GW-1:0] LEGACY_ACTIVE    = 16'h0001;
  localparam int            CYCLE_US         = 100;
  localparam int            CLK_MHZ          = 50;
  localparam int            CYCLE_CLKS       = CYCLE_US * CLK_MHZ;

  typedef struct packed {
    logic signed [DW-1:0] kp;
    logic        [GW-1:0] tn;
    logic        [DW-1:0] eMax;
    logic        [DW-1:0] yMax;
  } cml_gains_t;

  typedef struct packed {
    logic signed [DW-1:0] setPoint;
    logic signed [DW-1:0] actual;
    logic signed [DW-1:0] feedFwd;
  } cml_loop_in_t;

endpackage

// ### verification/cml_cascade_sva.sv
// Port-level checks of the cascade: loop enables, loop select, parameter set, cycle timing
`timescale 1ns/1ns
module cml_cascade_sva
  import cml_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire cml_mode_t            mode,
  input wire logic [7:0]           submode,
  input wire logic                 switchOn,
  input wire logic [GW-1:0]        legacyClosedSel,
  input wire logic [GW-1:0]        legacyOpenSel,
  input wire logic signed [DW-1:0] pwmCmd,
  input wire logic                 posLoopOn,
  input wire logic                 velLoopOn,
  input wire logic                 newParamsActive,
  input wire logic                 closedLoop,
  input wire logic                 cycleStrobe
);
  wire logic trqMode = mode == CML_PROFILE_TRQ || mode == CML_CYC_TRQ;
  wire logic velMode = mode == CML_VELOCITY || mode == CML_PROFILE_VEL || mode == CML_CYC_VEL;
  wire logic selZero = submode[SUB_LOOP_SELECT] ? legacyClosedSel == '0 : legacyOpenSel == '0;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_vel_loop_off: assert property (trqMode && submode[SUB_REAL_TORQUE] |-> !velLoopOn)
    else $error("velocity loop on in unlimited torque mode");
  chk_vel_loop_on: assert property (!trqMode && closedLoop |-> velLoopOn)
    else $error("velocity loop off outside torque modes");
  chk_pos_loop_mode: assert property (!trqMode && !velMode && closedLoop |-> posLoopOn)
    else $error("position loop off in a position mode");
  chk_pos_loop_vel: assert property (velMode && closedLoop |-> posLoopOn == submode[SUB_POS_IN_VEL])
    else $error("position loop does not follow its enable in velocity mode");
  chk_open_loop_off: assert property (!closedLoop |-> !posLoopOn && !velLoopOn)
    else $error("outer loop running in open loop");
  chk_pos_loop_trq: assert property (trqMode |-> !posLoopOn)
    else $error("position loop on in torque mode");
  chk_loop_sel: assert property (closedLoop == submode[SUB_LOOP_SELECT])
    else $error("closed loop flag differs from loop select bit");
  chk_strobe_gap: assert property (cycleStrobe |=> !cycleStrobe [*8])
    else $error("control cycles too close");
  chk_pwm_hold: assert property ($changed(pwmCmd) |-> cycleStrobe)
    else $error("pwm command changed inside a cycle");
  chk_new_params: assert property ($rose(switchOn) && selZero |-> ##[1:2] newParamsActive)
    else $error("new parameters not taken at switch-on");
  chk_legacy_keep: assert property ($rose(switchOn) && !selZero |-> ##[1:2] !newParamsActive)
    else $error("legacy parameters dropped at switch-on");
endmodule
bind cml_cascade cml_cascade_sva cml_cascade_sva_i (.mclk, .rst, .mode, .submode, .switchOn,
  .legacyClosedSel, .legacyOpenSel, .pwmCmd, .posLoopOn, .velLoopOn, .newParamsActive,
  .closedLoop, .cycleStrobe);

// ### verification/cml_motor_model.sv
// Behavioural motor with encoder feedback: winding current, speed and shaft position
`timescale 1ns/1ns
module cml_motor_model
  import cml_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 run,
  input  wire logic signed [DW-1:0] pwmCmd,
  input  wire logic                 cycleStrobe,
  output logic signed [DW-1:0]      actualPos,
  output logic signed [DW-1:0]      actualVel,
  output logic signed [DW-1:0]      actualCur
);
  // Crude first-order current lag, speed and position integrate; held at rest so the bench can set exact deviations
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      actualCur <= '0;
      actualVel <= '0;
      actualPos <= '0;
    end else if (cycleStrobe) begin
      actualCur <= actualCur + ((pwmCmd - actualCur) >>> 2);
      actualVel <= actualVel + (actualCur >>> 4);
      actualPos <= actualPos + actualVel;
    end
  end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the cascaded loop control driving a motor model
`timescale 1ns/1ns
module testbench;
  import cml_pkg::*;
  logic                 mclk = 0, rst = 1, switchOn = 0, voltFfWritten = 0, run = 0;
  cml_mode_t            mode = CML_PROFILE_POS;
  logic [7:0]           submode = 8'h01;
  logic [GW-1:0]        legacyClosedSel = 16'h0001, legacyOpenSel = 16'h0001;
  logic [GW-1:0]        voltFfFactor = 16'h0000, ff = 16'h0000;
  cml_gains_t           g = '0;
  logic signed [DW-1:0] targetTorque = '0, ratedVoltage = '0, pwmCmd, actualPos, actualVel;
  logic signed [DW-1:0] actualCur;
  logic                 posLoopOn, velLoopOn, newParamsActive, closedLoop, cycleStrobe;
  int                   n_mismatch = 0, comparisons = 0;
  always #10 mclk = ~mclk;
  cml_cascade cml_cascade_i (.mclk, .rst, .mode, .submode, .switchOn, .legacyClosedSel,
    .legacyOpenSel, .legacyPos(g), .legacyVel(g), .legacyCur(g), .newPos(g), .newVel(g),
    .newCur(g), .velFfFactor(ff), .accFfFactor(ff), .accScale(ff), .voltFfFactor,
    .voltFfWritten, .targetPos(targetTorque), .rampVel(targetTorque), .rampAcc(targetTorque),
    .targetTorque, .actualPos, .actualVel, .actualCur, .ratedVoltage, .pwmCmd, .posLoopOn,
    .velLoopOn, .newParamsActive, .closedLoop, .cycleStrobe);
  cml_motor_model cml_motor_model_i (.mclk, .rst, .run, .pwmCmd, .cycleStrobe, .actualPos,
    .actualVel, .actualCur);
  task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Returns at the falling edge inside the strobe cycle, where pwmCmd holds the new result
  task automatic wait_strobe();
    int n = 0;
    @(negedge mclk);
    while (cycleStrobe !== 1'b1 && n < 6000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 6000) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic t_modes();
    logic [7:0] subs [4] = '{8'h00, 8'h03, 8'h21, 8'h22};
    logic       trq, vel;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      mode = cml_mode_t'(i / 4);
      submode = subs[i % 4];
      trq = mode == CML_PROFILE_TRQ || mode == CML_CYC_TRQ;
      vel = mode == CML_VELOCITY || mode == CML_PROFILE_VEL || mode == CML_CYC_VEL;
      #1;
      cmp(posLoopOn, submode[0] && (vel ? submode[1] : !trq));
      cmp(velLoopOn, submode[0] && !(trq && submode[5]));
      cmp(closedLoop, submode[0]);
    end
  endtask
  task automatic pulse_on(input logic [GW-1:0] closedSel, input logic [7:0] sub);
    submode = sub;
    legacyClosedSel = closedSel;
    @(negedge mclk) switchOn = 1;
    repeat (3) @(negedge mclk);
    switchOn = 0;
    @(negedge mclk);
  endtask
  task automatic t_switch();
    pulse_on(16'h0001, 8'h01);
    cmp(newParamsActive, 1'b0);
    legacyOpenSel = 16'h0000;
    pulse_on(16'h0001, 8'h00);
    cmp(newParamsActive, 1'b1);
    pulse_on(16'h0000, 8'h01);
    cmp(newParamsActive, 1'b1);
  endtask
  task automatic t_volt();
    g = '{kp: 32'h0000_03E8, tn: 16'h0000, eMax: 32'h0000_0400, yMax: 32'h0000_0800};
    mode = CML_PROFILE_TRQ;
    submode = 8'h21;
    ratedVoltage = 32'h0000_0100;
    wait_strobe();
    wait_strobe();
    cmp(pwmCmd, 32'h0000_0100);
    voltFfWritten = 1;
    @(negedge mclk) voltFfWritten = 0;
    wait_strobe();
    cmp(pwmCmd, 32'h0000_0000);
  endtask
  task automatic t_current(input logic [DW-1:0] kp, input logic [DW-1:0] dev,
                           input logic [DW-1:0] tn, input logic [DW-1:0] exp);
    g.kp = kp;
    g.tn = tn[GW-1:0];
    targetTorque = dev;
    wait_strobe();
    cmp(pwmCmd, exp);
  endtask
  task automatic t_integral();
    logic signed [DW-1:0] first;
    g.tn = 16'h0064;
    targetTorque = 32'h0000_0040;
    wait_strobe();
    first = pwmCmd;
    wait_strobe();
    cmp(pwmCmd > first, 1'b1);
  endtask
  // Unit factors: feed-forward equals the ramp value; each loop doubles its deviation
  task automatic t_ffwd();
    g.tn = 16'h0000;
    ff = 16'h03E8;
    targetTorque = 32'h0000_0040;
    wait_strobe();
    cmp(pwmCmd, 32'h0000_0080);
    mode = CML_VELOCITY;
    submode = 8'h01;
    wait_strobe();
    cmp(pwmCmd, 32'h0000_0180);
    submode = 8'h03;
    wait_strobe();
    cmp(pwmCmd, 32'h0000_0380);
  endtask
  task automatic t_period();
    int n = 0;
    mode = CML_PROFILE_POS;
    run = 1;
    wait_strobe();
    do begin
      @(negedge mclk);
      n++;
    end while (cycleStrobe !== 1'b1 && n < 6000);
    cmp(n, CYCLE_CLKS + 3);
  endtask
  task automatic finish_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1800000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (10) @(negedge mclk);
    rst = 0;
    t_modes();
    t_switch();
    t_volt();
    t_current(32'h0000_03E8, 32'h0000_0400, 0, 32'h0000_0800);
    t_current(32'h0000_03E8, 32'h0000_0C00, 0, 32'h0000_0800);
    t_current(32'h0000_01F4, 32'h0000_0400, 0, 32'h0000_0400);
    t_current(32'h0000_03E8, 32'hFFFF_F000, 0, 32'hFFFF_F800);
    t_integral();
    t_ffwd();
    t_period();
    finish_test();
  end
endmodule

// ### verilog/cml_cascade.sv
// Cascaded position, velocity and current loops with feed-forward injection
`timescale 1ns/1ns
module cml_cascade
  import cml_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire cml_mode_t            mode,
  input  wire logic [7:0]           submode,
  input  wire logic                 switchOn,
  input  wire logic [GW-1:0]        legacyClosedSel,
  input  wire logic [GW-1:0]        legacyOpenSel,
  input  wire cml_gains_t           legacyPos,
  input  wire cml_gains_t           legacyVel,
  input  wire cml_gains_t           legacyCur,
  input  wire cml_gains_t           newPos,
  input  wire cml_gains_t           newVel,
  input  wire cml_gains_t           newCur,
  input  wire logic [GW-1:0]        velFfFactor,
  input  wire logic [GW-1:0]        accFfFactor,
  input  wire logic [GW-1:0]        accScale,
  input  wire logic [GW-1:0]        voltFfFactor,
  input  wire logic                 voltFfWritten,
  input  wire logic signed [DW-1:0] targetPos,
  input  wire logic signed [DW-1:0] rampVel,
  input  wire logic signed [DW-1:0] rampAcc,
  input  wire logic signed [DW-1:0] targetTorque,
  input  wire logic signed [DW-1:0] actualPos,
  input  wire logic signed [DW-1:0] actualVel,
  input  wire logic signed [DW-1:0] actualCur,
  input  wire logic signed [DW-1:0] ratedVoltage,
  output logic signed [DW-1:0]      pwmCmd,
  output logic                      posLoopOn,
  output logic                      velLoopOn,
  output logic                      newParamsActive,
  output logic                      closedLoop,
  output logic                      cycleStrobe
);

  typedef enum logic [1:0] {CML_PH_COUNT, CML_PH_POS, CML_PH_VEL, CML_PH_CUR} cml_phase_t;

  localparam int               CNT_W    = $clog2(CYCLE_CLKS);
  localparam logic [CNT_W-1:0] CYC_LAST = CNT_W'(CYCLE_CLKS - 1);

  logic [CNT_W-1:0]              cycCnt;
  logic [CNT_W-1:0]              next_cycCnt;
  cml_phase_t                    phase;
  cml_phase_t                    next_phase;
  logic                          curDone;
  logic                          useNew;
  logic                          switchOnQ;
  logic [GW-1:0]                 voltFactor;
  cml_gains_t                    gPos;
  cml_gains_t                    gVel;
  cml_gains_t                    gCur;
  logic signed [DW-1:0]          yPos;
  logic signed [DW-1:0]          yVel;
  logic signed [DW-1:0]          yCur;

  wire isTorque = (mode == CML_PROFILE_TRQ) || (mode == CML_CYC_TRQ);
  wire isPosMode = (mode == CML_PROFILE_POS) || (mode == CML_HOMING) ||
                   (mode == CML_INTERP_POS) || (mode == CML_CYC_POS) ||
                   (mode == CML_CLOCK_DIR);
  wire isVelMode = (mode == CML_VELOCITY) || (mode == CML_PROFILE_VEL) ||
                   (mode == CML_CYC_VEL);
  wire posEn = isPosMode || (isVelMode && submode[SUB_POS_IN_VEL]);
  wire velEn = !(isTorque && submode[SUB_REAL_TORQUE]);
  wire curEn = 1'b1;
  wire loopClosed = submode[SUB_LOOP_SELECT];

  // True permille divide: a shift by ten would lose 2.3 % at full scale
  wire signed [GW:0]      permille = $signed({1'b0, PERMILLE_FULL});
  wire signed [DW+2*GW:0] accDiv   = permille * permille;

  // Velocity feed-forward only where the position loop runs
  wire signed [DW+GW:0] velFfProd = rampVel * $signed({1'b0, velFfFactor});
  wire signed [DW-1:0]  velFf = posEn ? DW'(velFfProd / permille) : '0;
  wire signed [DW+2*GW:0] accFfProd = rampAcc * $signed({1'b0, accFfFactor}) *
                                      $signed({1'b0, accScale});
  wire signed [DW-1:0]  accFf = isTorque ? '0 :
                                DW'(accFfProd / accDiv);
  wire signed [DW+GW:0] voltProd = ratedVoltage * $signed({1'b0, voltFactor});
  wire signed [DW-1:0]  voltFf = (voltFactor == '0) ? '0 :
                                 DW'(voltProd / permille);

  // Velocity set point: position output plus feed-forward, or ramp velocity without the position loop
  wire signed [DW-1:0] velSet = posEn ? yPos : rampVel;
  wire signed [DW-1:0] curSet = velEn ? yVel : targetTorque;

  cml_loop_in_t posIn;
  cml_loop_in_t velIn;
  cml_loop_in_t curIn;
  assign posIn = '{setPoint: targetPos, actual: actualPos, feedFwd: '0};
  assign velIn = '{setPoint: velSet + velFf, actual: actualVel, feedFwd: '0};
  assign curIn = '{setPoint: curSet + accFf, actual: actualCur, feedFwd: voltFf};

  // Choice latched only at switch-on, so a running drive never swaps gain sets
  wire selZero      = (loopClosed ? legacyClosedSel : legacyOpenSel) == '0;
  wire switchOnRise = switchOn && !switchOnQ;

  always_ff @(posedge mclk) begin
    if (rst) begin
      useNew    <= 1'b0;
      switchOnQ <= 1'b0;
    end else begin
      switchOnQ <= switchOn;
      if (switchOnRise)
        useNew <= selZero;
    end
  end

  // Gain sets land one edge after the selection
  always_ff @(posedge mclk) begin
    if (rst) begin
      gPos <= '0;
      gVel <= '0;
      gCur <= '0;
    end else begin
      gPos <= useNew ? newPos : legacyPos;
      gVel <= useNew ? newVel : legacyVel;
      gCur <= useNew ? newCur : legacyCur;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst)
      voltFactor <= VOLT_FF_DEFAULT;
    else if (voltFfWritten)
      voltFactor <= voltFfFactor;
  end

  // Fixed control cycle: count, then one clock each for position, velocity and current
  wire cycEnd  = cycCnt == CYC_LAST;
  wire stepPos = phase == CML_PH_POS;
  wire stepVel = phase == CML_PH_VEL;
  wire stepCur = phase == CML_PH_CUR;

  always_comb begin
    next_phase  = phase;
    next_cycCnt = cycCnt;
    case (phase)
      CML_PH_COUNT: begin
        if (cycEnd) begin
          next_cycCnt = '0;
          next_phase  = CML_PH_POS;
        end else begin
          next_cycCnt = cycCnt + 1'b1;
        end
      end
      CML_PH_POS: next_phase = CML_PH_VEL;
      CML_PH_VEL: next_phase = CML_PH_CUR;
      CML_PH_CUR: next_phase = CML_PH_COUNT;
      default:    next_phase = CML_PH_COUNT;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cycCnt <= '0;
      phase  <= CML_PH_COUNT;
    end else begin
      cycCnt <= next_cycCnt;
      phase  <= next_phase;
    end
  end

  cml_pi_stage posStage (
    .mclk   (mclk),
    .rst    (rst),
    .step   (stepPos),
    .enable (posEn && loopClosed),
    .gains  (gPos),
    .loopIn (posIn),
    .y      (yPos)
  );

  cml_pi_stage velStage (
    .mclk   (mclk),
    .rst    (rst),
    .step   (stepVel),
    .enable (velEn && loopClosed),
    .gains  (gVel),
    .loopIn (velIn),
    .y      (yVel)
  );

  cml_pi_stage curStage (
    .mclk   (mclk),
    .rst    (rst),
    .step   (stepCur),
    .enable (curEn),
    .gains  (gCur),
    .loopIn (curIn),
    .y      (yCur)
  );

  // The current stage result exists only after its step edge; publish it one edge later
  always_ff @(posedge mclk) begin
    if (rst) begin
      curDone     <= 1'b0;
      pwmCmd      <= '0;
      cycleStrobe <= 1'b0;
    end else begin
      curDone     <= stepCur;
      cycleStrobe <= curDone;
      if (curDone)
        pwmCmd <= yCur;
    end
  end

  assign posLoopOn       = posEn && loopClosed;
  assign velLoopOn       = velEn && loopClosed;
  assign newParamsActive = useNew;
  assign closedLoop      = loopClosed;

endmodule

// ### verilog/cml_pi_stage.sv
// One proportional-integral stage with output clamp, shared by all three loops
`timescale 1ns/1ns
module cml_pi_stage
  import cml_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 step,
  input  wire logic                 enable,
  input  wire cml_gains_t           gains,
  input  wire cml_loop_in_t         loopIn,
  output logic signed [DW-1:0]      y
);

  logic signed [DW+GW+1:0] integ;
  wire  signed [DW:0]      err  = {loopIn.setPoint[DW-1], loopIn.setPoint} -
                                  {loopIn.actual[DW-1], loopIn.actual};
  wire  signed [DW:0]      emax = $signed({1'b0, gains.eMax});
  wire  signed [DW:0]      ymax = $signed({1'b0, gains.yMax});
  // Scale so that err == eMax at unity gain gives exactly yMax
  wire  signed [2*DW+GW+1:0] pNum = err * ymax * $signed({1'b0, gains.kp[GW-1:0]});
  wire  signed [2*DW+GW+1:0] pDen = (emax == '0) ? 1 : emax * $signed({1'b0, GAIN_UNITY});
  wire  signed [DW+GW+1:0]   pTerm = (DW+GW+2)'(pNum / pDen);
  // Integral step divided by reset time: shorter time grows faster
  wire  signed [DW+GW+1:0]   iStep = (gains.tn == '0) ? '0 :
                                     (DW+GW+2)'(pTerm / $signed({1'b0, gains.tn}));
  wire  signed [DW+GW+1:0]   iNext = (gains.tn == '0) ? '0 : integ + iStep;
  // Feed-forward joins after the integral, never accumulated
  wire  signed [DW+GW+1:0]   sum  = pTerm + iNext +
                                    (DW+GW+2)'(loopIn.feedFwd);
  wire  signed [DW+GW+1:0]   lim  = (DW+GW+2)'(ymax);
  wire  signed [DW-1:0]      clamped = (sum > lim)  ? DW'(ymax) :
                                       (sum < -lim) ? DW'(-ymax) : DW'(sum);

  always_ff @(posedge mclk) begin
    if (rst || !enable) begin
      integ <= '0;
      y     <= '0;
    end else if (step) begin
      // Hold integral while saturated to avoid windup
      if (sum <= lim && sum >= -lim)
        integ <= iNext;
      y <= clamped;
    end
  end

endmodule
